// *** verilog/tcpg_timer.sv ***
// capture / compare timer: restart capture, square wave, pulse output
// assumes avalon-mm master on clk; capture_in_a from an outside pin
`timescale 1ns/1ns
`default_nettype none
`include "tcpg_cfg.svh"
module tcpg_timer
    import tcpg_pkg::*;
(
    input wire logic clk, // 250 mhz system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read strobe
    input wire logic avs_write, // write strobe
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic capture_in_a, // capture pin
    output logic wave_out_pin, // waveform output
    output logic irq // level interrupt
);
    tcpg_edge_if eif();
    logic [15:0] count_reg, cmp_cap_a, cmp_cap_b;
    logic [7:0] prescale_edge_cfg, timer_mode_ctl, capcmp_ctl;
    logic [7:0] wave_out_ctl;
    logic [2:0] status, mask;
    logic [5:0] pre_cnt;
    logic wave_q, ack;
    logic [15:0] next_count, next_a, next_b;
    logic [7:0] next_pre_cfg, next_mode, next_capcmp, next_wave_ctl;
    logic [2:0] next_status, next_mask, ev;
    logic [5:0] next_pre;
    logic next_wave_q, next_ack;
    logic [31:0] next_rdata;
    logic tick, wr, match_a, match_b, restart_cap, ovf_ev;
    tcpg_mode_t mode;
    tcpg_edge_t edge_sel;
    logic wave_out_enable, toggle_on_match_a, pulse_pattern_mode;

    assign mode = tcpg_mode_t'(timer_mode_ctl[`TCPG_MODE_LSB +: 2]);
    assign edge_sel = tcpg_edge_t'(prescale_edge_cfg[`TCPG_PRE_EDGE_LSB +: 2]);
    assign wave_out_enable = wave_out_ctl[`TCPG_WAVE_EN_BIT];
    assign toggle_on_match_a = wave_out_ctl[`TCPG_WAVE_TOG_BIT];
    assign pulse_pattern_mode = wave_out_ctl[`TCPG_WAVE_PULSE_BIT];
    assign eif.tick = tick;
    assign eif.sel = edge_sel;

    tcpg_edge_filter u_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(capture_in_a),
        .eif(eif.filt)
    );

    // count clock: clk divided by 2^sel for sel 0..5, by 32 for sel 6..7; stopped when mode is 0 unless sel is 0
    always_comb begin
        case (prescale_edge_cfg[`TCPG_PRE_SEL_LSB +: 3])
            3'h0: tick = 1'b1;
            3'h1: tick = pre_cnt[0];
            3'h2: tick = &pre_cnt[1:0];
            3'h3: tick = &pre_cnt[2:0];
            3'h4: tick = &pre_cnt[3:0];
            default: tick = &pre_cnt[4:0];
        endcase
    end
    assign next_pre = (mode == TCPG_STOP) ? 6'h00 : 6'(pre_cnt + 6'h01);

    assign match_a = tick && (mode == TCPG_CLEAR_A) && (count_reg == cmp_cap_a);
    assign match_b = tick && (mode != TCPG_STOP) && (count_reg == cmp_cap_b);
    // both-edge selection captures nothing
    assign restart_cap = (mode == TCPG_RESTART) && eif.valid_edge
        && (edge_sel != TCPG_EDGE_BOTH);
    assign ovf_ev = tick && (mode != TCPG_STOP) && (count_reg == 16'hffff)
        && !match_a;
    // write lands on the edge where the master sees waitrequest low
    assign wr = avs_write && ack;

    always_comb begin
        next_count = count_reg;
        if (mode == TCPG_STOP) begin
            next_count = 16'h0000;
        end else if (restart_cap) begin
            next_count = 16'h0000;
        end else if (match_a) begin
            next_count = 16'h0000;
        end else if (tick) begin
            next_count = 16'(count_reg + 16'h0001);
        end
    end

    // output: toggle on match a, or pulse set at clear and reset after b
    always_comb begin
        next_wave_q = wave_q;
        if (!wave_out_enable) begin
            next_wave_q = wave_out_ctl[`TCPG_WAVE_INIT_BIT];
        end else if (pulse_pattern_mode) begin
            if (match_a) begin
                next_wave_q = 1'b1;
            end else if (match_b) begin
                next_wave_q = 1'b0;
            end
        end else if (toggle_on_match_a && match_a) begin
            next_wave_q = ~wave_q;
        end
    end

    always_comb begin
        ev = 3'h0;
        ev[`TCPG_ST_MATCH_BIT] = match_a;
        ev[`TCPG_ST_CAP_BIT] = restart_cap;
        ev[`TCPG_ST_OVF_BIT] = ovf_ev;
        next_status = status;
        if (wr && avs_address == `TCPG_OFS_STATUS && avs_byteenable[0]) begin
            next_status = status & ~avs_writedata[2:0];
        end
        next_status = next_status | ev;
        next_mask = mask;
        if (wr && avs_address == `TCPG_OFS_MASK && avs_byteenable[0]) begin
            next_mask = avs_writedata[2:0];
        end
    end

    always_comb begin
        next_a = cmp_cap_a;
        next_b = cmp_cap_b;
        next_pre_cfg = prescale_edge_cfg;
        next_mode = timer_mode_ctl;
        next_capcmp = capcmp_ctl;
        next_wave_ctl = wave_out_ctl;
        if (wr) begin
            case (avs_address)
                `TCPG_OFS_CMP_A: begin
                    if (avs_byteenable[0]) next_a[7:0] = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_a[15:8] = avs_writedata[15:8];
                end
                `TCPG_OFS_CMP_B: begin
                    if (avs_byteenable[0]) next_b[7:0] = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_b[15:8] = avs_writedata[15:8];
                end
                `TCPG_OFS_PRESCALE: begin
                    if (avs_byteenable[0]) next_pre_cfg = avs_writedata[7:0];
                end
                `TCPG_OFS_MODE: begin
                    if (avs_byteenable[0]) next_mode = avs_writedata[7:0];
                end
                `TCPG_OFS_CAPCMP: begin
                    if (avs_byteenable[0]) next_capcmp = avs_writedata[7:0];
                end
                `TCPG_OFS_WAVE: begin
                    if (avs_byteenable[0]) next_wave_ctl = avs_writedata[7:0];
                end
                default: ;
            endcase
        end
        // captured value is the count before the clear
        if (restart_cap) begin
            next_b = count_reg;
        end
    end

    // one wait cycle per access so read data come from a flip-flop
    always_comb begin
        next_ack = (avs_read || avs_write) && !ack;
        // latched only on a new read, so data stand until the next one
        next_rdata = avs_readdata;
        if (avs_read && !ack) begin
            case (avs_address)
                `TCPG_OFS_COUNT: next_rdata = {16'h0000, count_reg};
                `TCPG_OFS_CMP_A: next_rdata = {16'h0000, cmp_cap_a};
                `TCPG_OFS_CMP_B: next_rdata = {16'h0000, cmp_cap_b};
                `TCPG_OFS_PRESCALE: next_rdata = {24'h000000,
                    prescale_edge_cfg};
                `TCPG_OFS_MODE: next_rdata = {24'h000000, timer_mode_ctl};
                `TCPG_OFS_CAPCMP: next_rdata = {24'h000000, capcmp_ctl};
                `TCPG_OFS_WAVE: next_rdata = {24'h000000, wave_out_ctl};
                `TCPG_OFS_STATUS: next_rdata = {29'h00000000, status};
                `TCPG_OFS_MASK: next_rdata = {29'h00000000, mask};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= 16'h0000;
            cmp_cap_a <= `TCPG_RST_CMP;
            cmp_cap_b <= `TCPG_RST_CMP;
            prescale_edge_cfg <= `TCPG_RST_BYTE;
            timer_mode_ctl <= `TCPG_RST_BYTE;
            capcmp_ctl <= `TCPG_RST_BYTE;
            wave_out_ctl <= `TCPG_RST_BYTE;
            status <= 3'h0;
            mask <= 3'h0;
            pre_cnt <= 6'h00;
            wave_q <= 1'b0;
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
            wave_out_pin <= 1'b0;
            irq <= 1'b0;
        end else begin
            count_reg <= next_count;
            cmp_cap_a <= next_a;
            cmp_cap_b <= next_b;
            prescale_edge_cfg <= next_pre_cfg;
            timer_mode_ctl <= next_mode;
            capcmp_ctl <= next_capcmp;
            wave_out_ctl <= next_wave_ctl;
            status <= next_status;
            mask <= next_mask;
            pre_cnt <= next_pre;
            wave_q <= next_wave_q;
            ack <= next_ack;
            avs_readdata <= next_rdata;
            avs_waitrequest <= !next_ack;
            wave_out_pin <= next_wave_q;
            irq <= |(next_status & next_mask);
        end
    end
endmodule // tcpg_timer
`default_nettype wire

// *** verilog/tcpg_cfg.svh ***
// constants for the capture / pulse timer block: offsets, fields, resets
// assumes a 32-bit avalon-mm slave with word addresses as byte offsets
`ifndef TCPG_CFG_SVH
`define TCPG_CFG_SVH
`define TCPG_OFS_COUNT 8'h00
`define TCPG_OFS_CMP_A 8'h04
`define TCPG_OFS_CMP_B 8'h08
`define TCPG_OFS_PRESCALE 8'h0c
`define TCPG_OFS_MODE 8'h10
`define TCPG_OFS_CAPCMP 8'h14
`define TCPG_OFS_WAVE 8'h18
`define TCPG_OFS_STATUS 8'h1c
`define TCPG_OFS_MASK 8'h20
`define TCPG_PRE_SEL_LSB 0
`define TCPG_PRE_EDGE_LSB 4
`define TCPG_MODE_LSB 2
`define TCPG_WAVE_EN_BIT 0
`define TCPG_WAVE_TOG_BIT 1
`define TCPG_WAVE_PULSE_BIT 4
`define TCPG_WAVE_INIT_BIT 5
`define TCPG_CC_A_CAP_BIT 0
`define TCPG_ST_MATCH_BIT 0
`define TCPG_ST_CAP_BIT 1
`define TCPG_ST_OVF_BIT 2
`define TCPG_RST_CMP 16'h0000
`define TCPG_RST_BYTE 8'h00
`endif

// *** verilog/tcpg_pkg.sv ***
// types shared by the capture / pulse timer files
// assumes tcpg_cfg.svh is on the include path
`include "tcpg_cfg.svh"
package tcpg_pkg;
    typedef enum logic [1:0] {
        TCPG_STOP = 2'b00,
        TCPG_FREE = 2'b01,
        TCPG_RESTART = 2'b11,
        TCPG_CLEAR_A = 2'b10
    } tcpg_mode_t;
    typedef enum logic [1:0] {
        TCPG_EDGE_FALL = 2'b00,
        TCPG_EDGE_RISE = 2'b01,
        TCPG_EDGE_NONE = 2'b10,
        TCPG_EDGE_BOTH = 2'b11
    } tcpg_edge_t;
endpackage

// *** verilog/tcpg_edge_if.sv ***
// link between the timer core and its capture-input filter
// assumes one clock; tick marks a count-clock sample
`timescale 1ns/1ns
`default_nettype none
interface tcpg_edge_if;
    import tcpg_pkg::*;
    logic tick;
    tcpg_edge_t sel;
    logic valid_edge;
    modport core (output tick, output sel, input valid_edge);
    modport filt (input tick, input sel, output valid_edge);
endinterface
`default_nettype wire

// *** verilog/tcpg_edge_filter.sv ***
// capture-input filter: sync, two-sample filter, edge select
// assumes pin is asynchronous to clk; tick from the core's prescaler
`timescale 1ns/1ns
`default_nettype none
module tcpg_edge_filter
    import tcpg_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic pin, // raw capture pin
    tcpg_edge_if.filt eif // tick, select, edge out
);
    logic sync1, sync2, samp0, level;
    logic next_samp0, next_level, next_valid;
    always_comb begin
        next_samp0 = samp0;
        next_level = level;
        next_valid = 1'b0;
        if (eif.tick) begin
            next_samp0 = sync2;
            // level changes only after two equal samples
            if (samp0 == sync2 && sync2 != level) begin
                next_level = sync2;
                case (eif.sel)
                    TCPG_EDGE_RISE: next_valid = sync2;
                    TCPG_EDGE_FALL: next_valid = ~sync2;
                    TCPG_EDGE_BOTH: next_valid = 1'b1;
                    default: next_valid = 1'b0;
                endcase
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            samp0 <= 1'b0;
            level <= 1'b0;
            eif.valid_edge <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            samp0 <= next_samp0;
            level <= next_level;
            eif.valid_edge <= next_valid;
        end
    end
endmodule // tcpg_edge_filter
`default_nettype wire

// *** sim/tcpg_pulse_src.sv ***
// far-side pulse source that drives the capture pin
// assumes one caller at a time; pin changes only just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module tcpg_pulse_src (
    input wire logic clk, // timer clock
    output logic pin // capture pin
);
    initial pin = 1'b0;
    // level stands for n clocks, so a one-clock blip is possible
    task automatic hold(input logic lvl, input int n);
        @(posedge clk);
        pin <= lvl;
        repeat (n - 1) @(posedge clk);
    endtask
endmodule // tcpg_pulse_src
`default_nettype wire

// *** sim/tcpg_timer_properties.sv ***
// port checker for the capture / pulse timer
// assumes bound to tcpg_timer; shadows follow completed bus writes
`timescale 1ns/1ns
`default_nettype none
`include "tcpg_cfg.svh"
module tcpg_timer_properties (
    input wire logic clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic [7:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // lanes
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic capture_in_a, // pin
    input wire logic wave_out_pin, // wave
    input wire logic irq // interrupt
);
    logic [7:0] mode_sh;
    logic [7:0] mask_sh;
    logic req;
    logic wr_ok;
    assign req = avs_read | avs_write;
    assign wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_sh <= 8'h00;
            mask_sh <= 8'h00;
        end else if (wr_ok && avs_address == `TCPG_OFS_MODE) begin
            mode_sh <= avs_writedata[7:0];
        end else if (wr_ok && avs_address == `TCPG_OFS_MASK) begin
            mask_sh <= avs_writedata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence req_new;
        req && avs_waitrequest && !$past(req && avs_waitrequest);
    endsequence
    sequence ack_pulse;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    one_wait_a: assert property (req_new |=> ack_pulse)
        else $error("access not answered after one wait state");
    idle_stall_a: assert property (!req |-> avs_waitrequest)
        else $error("waitrequest low with no access");
    ack_req_a: assert property (!avs_waitrequest |-> req && $past(req))
        else $error("answer without a held request");
    rd_hold_a: assert property (!req && $past(!req) |-> $stable(avs_readdata))
        else $error("read data moved between accesses");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest
        && avs_address > `TCPG_OFS_MASK |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    stop_count_a: assert property (mode_sh[3:2] == 2'h0 && avs_read
        && !avs_waitrequest && avs_address == `TCPG_OFS_COUNT
        |-> avs_readdata[15:0] == 16'h0000)
        else $error("count moves while stopped");
    mask_quiet_a: assert property (mask_sh[2:0] == 3'h0
        && $past(mask_sh[2:0]) == 3'h0 |-> !irq)
        else $error("irq high with all sources masked");
    reset_exit_a: assert property ($fell(sys_rst)
        |-> avs_waitrequest && !irq && !wave_out_pin)
        else $error("outputs not at reset level");
endmodule // tcpg_timer_properties
bind tcpg_timer tcpg_timer_properties i_props (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_in_a(capture_in_a), .wave_out_pin(wave_out_pin), .irq(irq));
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the capture / pulse timer
// assumes one wait state per access; count clock mostly every clk
`timescale 1ns/1ns
`default_nettype none
`include "tcpg_cfg.svh"
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic capture_in_a;
    logic wave_out_pin;
    logic irq;
    logic [31:0] rd_val;
    int errors = 0;
    int n_compared = 0;
    int n1;
    int n2;
    always #2 clk = ~clk;
    tcpg_timer i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .capture_in_a(capture_in_a), .wave_out_pin(wave_out_pin), .irq(irq));
    tcpg_pulse_src i_src (.clk(clk), .pin(capture_in_a));
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd_val = avs_readdata;
        avs_read <= 1'b0;
    endtask
    // clocks until the wave pin changes, capped so a dead pin cannot hang
    task automatic gap(output int n);
        logic w;
        w = wave_out_pin;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wave_out_pin === w && n < 200);
    endtask
    task finish_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        // run is about 66k clocks, most of it the overflow wait
        #300000;
        errors++;
        finish_test;
    end
    initial begin
        logic v;
        logic [31:0] pcfg;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`TCPG_OFS_CMP_A);
        chk("cmp_a reset", rd_val, 32'h00000000);
        wr(8'h24, 32'h00000055);
        rd(8'h24);
        chk("unmapped", rd_val, 32'h00000000);
        wr(`TCPG_OFS_PRESCALE, 32'h00000000);
        wr(`TCPG_OFS_CAPCMP, 32'h00000000);
        wr(`TCPG_OFS_WAVE, 32'h00000003);
        wr(`TCPG_OFS_CMP_A, 32'h00000003);
        wr(`TCPG_OFS_MODE, 32'h00000008);
        gap(n1);
        repeat (2) begin
            gap(n1);
            chk("square half period", n1, 4);
        end
        wr(`TCPG_OFS_PRESCALE, 32'h00000001);
        gap(n1);
        gap(n1);
        chk("square half period slow", n1, 8);
        wr(`TCPG_OFS_PRESCALE, 32'h00000000);
        rd(`TCPG_OFS_STATUS);
        chk("match flag", rd_val & 32'h1, 32'h1);
        wr(`TCPG_OFS_MASK, 32'h00000001);
        repeat (3) @(posedge clk);
        chk("irq unmasked", irq, 1'b1);
        wr(`TCPG_OFS_MASK, 32'h00000000);
        repeat (3) @(posedge clk);
        chk("irq masked", irq, 1'b0);
        wr(`TCPG_OFS_MODE, 32'h00000000);
        rd(`TCPG_OFS_COUNT);
        chk("stopped count", rd_val, 32'h00000000);
        // free run: one count per clock, then roll over 0xffff
        wr(`TCPG_OFS_MODE, 32'h00000004);
        rd(`TCPG_OFS_COUNT);
        n1 = rd_val;
        rd(`TCPG_OFS_COUNT);
        chk("free count step", rd_val - n1, 3);
        repeat (65540) @(posedge clk);
        rd(`TCPG_OFS_STATUS);
        chk("overflow flag", rd_val & 32'h4, 32'h4);
        rd(`TCPG_OFS_STATUS);
        chk("overflow sticky", rd_val & 32'h4, 32'h4);
        wr(`TCPG_OFS_MODE, 32'h00000000);
        wr(`TCPG_OFS_STATUS, 32'h00000007);
        rd(`TCPG_OFS_STATUS);
        chk("status cleared", rd_val, 32'h00000000);
        wr(`TCPG_OFS_CAPCMP, 32'h00000000);
        wr(`TCPG_OFS_CMP_A, 32'h00000005);
        wr(`TCPG_OFS_CMP_B, 32'h00000001);
        wr(`TCPG_OFS_WAVE, 32'h00000013);
        wr(`TCPG_OFS_PRESCALE, 32'h00000000);
        wr(`TCPG_OFS_MODE, 32'h00000008);
        gap(n1);
        if (wave_out_pin !== 1'b1) gap(n1);
        gap(n1);
        gap(n2);
        chk("pulse high", n1, 2);
        chk("pulse period", n1 + n2, 6);
        wr(`TCPG_OFS_MODE, 32'h00000000);
        wr(`TCPG_OFS_WAVE, 32'h00000000);
        wr(`TCPG_OFS_MASK, 32'h00000002);
        wr(`TCPG_OFS_STATUS, 32'h00000007);
        // fall, rise, then both and none, which must capture nothing
        for (int e = 0; e < 4; e++) begin
            v = (e == 1);
            case (e)
                0: pcfg = 32'h00000000;
                1: pcfg = 32'h00000010;
                2: pcfg = 32'h00000030;
                default: pcfg = 32'h00000020;
            endcase
            wr(`TCPG_OFS_PRESCALE, pcfg);
            wr(`TCPG_OFS_MODE, 32'h0000000c);
            i_src.hold(!v, 10);
            i_src.hold(v, 15);
            i_src.hold(!v, 25);
            i_src.hold(v, 15);
            i_src.hold(!v, 10);
            chk("capture irq", irq, (e < 2));
            rd(`TCPG_OFS_CMP_B);
            chk("captured width", rd_val, 32'd39);
            rd(`TCPG_OFS_STATUS);
            chk("capture flag", rd_val & 32'h2, (e < 2) ? 32'h2 : 32'h0);
            wr(`TCPG_OFS_STATUS, 32'h00000007);
        end
        wr(`TCPG_OFS_PRESCALE, 32'h00000010);
        i_src.hold(1'b0, 10);
        wr(`TCPG_OFS_STATUS, 32'h00000007);
        i_src.hold(1'b1, 1);
        i_src.hold(1'b0, 10);
        rd(`TCPG_OFS_STATUS);
        chk("blip rejected", rd_val & 32'h2, 32'h0);
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
